// *** src/acc_adc_control.v ***
`timescale 1ns/1ps
// What this block does
// - Interrupts off: flag set per conversion
// - Flag holds until result register read
// - Interrupts on: flag never set, reads 0
// - Interrupts on: request at conversion end
// - Result read or control write drops request
// - Reset clears flag, enable, continuous bit
// - Continuous mode converts repeatedly, overwriting result
// - Single mode converts once then stops
// - Codes 0-3 pick pins 0,1,4,5
// - All-ones code powers converter off
// - Reset selects powered-off channel code
// - Two codes pick high/low reference nodes
// - One 8-bit result loaded per conversion
// - 3-bit prescaler divides bus clock
// - Conversion within 17 ADC clocks, input stable
// - 16 ADC clocks, start after control write
// - Stop mode aborts, resumes after exit
module acc_adc_control
(
	input wire clk,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire stop_mode,
	input wire [7:0] sar_result,
	input wire sar_ready,
	output reg sar_start,
	output reg sar_power_on,
	output reg [2:0] analog_mux_select,
	output reg port_a_pin0_analog,
	output reg port_a_pin1_analog,
	output reg port_a_pin4_analog,
	output reg port_a_pin5_analog,
	output reg conversion_irq
);
`include "acc_consts.vh"
	// Mux select encodings for the analog path
	localparam MUX_PIN0 = 3'h0;
	localparam MUX_PIN1 = 3'h1;
	localparam MUX_PIN4 = 3'h2;
	localparam MUX_PIN5 = 3'h3;
	localparam MUX_REF_HIGH = 3'h4;
	localparam MUX_REF_LOW = 3'h5;
	localparam MUX_NONE = 3'h7;
	// Converter sequencer states
	localparam ST_IDLE = 2'h0;
	localparam ST_CONVERT = 2'h1;
	localparam ST_HOLD = 2'h2;

	// Status/control fields
	reg conversion_done_flag;
	reg conversion_irq_enable;
	reg continuous_convert;
	reg [4:0] channel_select;
	// Result and prescaler storage
	reg [7:0] adc_result_data;
	reg [2:0] prescale_select;
	// Data-phase bookkeeping
	reg dp_write;
	reg dp_read;
	reg [3:0] dp_addr;
	// Sequencer
	reg [1:0] state;
	reg [4:0] cycle_count;
	// Stop mode pin synchroniser
	reg stop_meta;
	reg stop_sync;
	// SAR ready synchroniser, analog side runs off its own timing
	reg ready_meta;
	reg ready_sync;
	// Divided ADC clock tick
	wire adc_tick;
	// Access strobes for both bus phases, plus power-off and conversion-end decodes
	wire wr_ctrl;
	wire wr_div;
	wire rd_result;
	wire addr_phase;
	wire power_off;
	wire conv_end;

	// Pin decode used by both mux and port overrides
	function [2:0] acc_mux_decode;
		input [4:0] code;
		begin
			if (code <= `ACC_CH_LAST_PIN)
				acc_mux_decode = code[2:0];
			else if (code == `ACC_CH_REF_HIGH)
				acc_mux_decode = MUX_REF_HIGH;
			else if (code == `ACC_CH_REF_LOW)
				acc_mux_decode = MUX_REF_LOW;
			else
				acc_mux_decode = MUX_NONE;
		end
	endfunction

	assign addr_phase = hsel & hready & htrans[`ACC_HTRANS_NONSEQ_BIT];
	assign wr_ctrl = dp_write & (dp_addr == `ACC_ADDR_STATUS_CONTROL);
	assign wr_div = dp_write & (dp_addr == `ACC_ADDR_CLOCK_DIVIDER);
	assign rd_result = dp_read & (dp_addr == `ACC_ADDR_RESULT_DATA);
	assign power_off = (channel_select == `ACC_CH_POWER_OFF);
	assign conv_end = (state == ST_CONVERT) & adc_tick & (cycle_count == `ACC_CONV_CYCLES);

	// Prescaler restarts on control writes so conversion aligns to its edge
	acc_prescaler u_prescaler
	(
		.clk(clk),
		.arst_n(arst_n),
		.prescale_select(prescale_select),
		.restart(wr_ctrl),
		.adc_tick(adc_tick)
	);

	// Two-flop synchronisers for asynchronous inputs
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stop_meta <= 1'b0;
			stop_sync <= 1'b0;
			ready_meta <= 1'b0;
			ready_sync <= 1'b0;
		end
		else
		begin
			stop_meta <= stop_mode;
			stop_sync <= stop_meta;
			ready_meta <= sar_ready;
			ready_sync <= ready_meta;
		end
	end

	// AHB address phase capture; zero wait states, always OKAY
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_addr <= 4'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			dp_write <= addr_phase & hwrite;
			dp_read <= addr_phase & ~hwrite;
			dp_addr <= haddr[`ACC_ADDR_BITS-1:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Read data registered at the address phase so it stands in the data phase
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			hrdata <= `ACC_ZERO32;
		else if (addr_phase & ~hwrite)
		begin
			hrdata <= `ACC_ZERO32;
			case (haddr[`ACC_ADDR_BITS-1:0])
				`ACC_ADDR_STATUS_CONTROL:
				begin
					// Flag forced low while interrupts enabled
					hrdata[`ACC_BIT_DONE] <= conversion_done_flag & ~conversion_irq_enable;
					hrdata[`ACC_BIT_IRQ_EN] <= conversion_irq_enable;
					hrdata[`ACC_BIT_CONT] <= continuous_convert;
					hrdata[`ACC_CH_HI:`ACC_CH_LO] <= channel_select;
				end
				`ACC_ADDR_RESULT_DATA:
					hrdata[7:0] <= adc_result_data;
				`ACC_ADDR_CLOCK_DIVIDER:
					hrdata[`ACC_DIV_HI:`ACC_DIV_LO] <= prescale_select;
				default:
					hrdata <= `ACC_ZERO32; // Unmapped reads return zero
			endcase
		end
		else
			hrdata <= `ACC_ZERO32;
	end

	// Control fields; flag bit of write data ignored
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			conversion_irq_enable <= 1'b0;
			continuous_convert <= 1'b0;
			channel_select <= `ACC_CH_RESET;
			prescale_select <= `ACC_DIV_RESET;
		end
		else
		begin
			if (wr_ctrl)
			begin
				// Written flag bit discarded; software keeps it 0
				conversion_irq_enable <= hwdata[`ACC_BIT_IRQ_EN];
				continuous_convert <= hwdata[`ACC_BIT_CONT];
				channel_select <= hwdata[`ACC_CH_HI:`ACC_CH_LO];
			end
			if (wr_div)
				prescale_select <= hwdata[`ACC_DIV_HI:`ACC_DIV_LO];
		end
	end

	// Completion flag and interrupt level; a new completion beats a clear
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			conversion_done_flag <= 1'b0;
			conversion_irq <= 1'b0;
		end
		else
		begin
			if (conv_end & ~conversion_irq_enable)
				conversion_done_flag <= 1'b1;
			else if (rd_result)
				conversion_done_flag <= 1'b0;
			if (conv_end & conversion_irq_enable)
				conversion_irq <= 1'b1;
			else if (rd_result | wr_ctrl)
				conversion_irq <= 1'b0;
		end
	end

	// Result latch at conversion end; continuous mode overwrites freely
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			adc_result_data <= 8'h00;
		else if (conv_end)
			adc_result_data <= sar_result;
	end

	// Sequencer: 16 ADC ticks per conversion, kicked by control writes
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= ST_IDLE;
			cycle_count <= 5'h00;
			sar_start <= 1'b0;
		end
		else if (stop_sync | (power_off & ~wr_ctrl))
		begin
			// Stop mode or power-off aborts; a write leaving power-off starts at once
			state <= stop_sync & ~power_off & (state != ST_IDLE) ? ST_HOLD : ST_IDLE;
			cycle_count <= 5'h00;
			sar_start <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			// Write restarts any running conversion
			state <= ST_CONVERT;
			cycle_count <= 5'h00;
			sar_start <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					sar_start <= 1'b0;
				end
				ST_HOLD:
				begin
					// Resume after stop exit with a fresh conversion
					state <= ST_CONVERT;
					cycle_count <= 5'h00;
				end
				ST_CONVERT:
				begin
					if (adc_tick)
					begin
						sar_start <= (cycle_count == 5'h00);
						if (cycle_count == `ACC_CONV_CYCLES)
						begin
							cycle_count <= 5'h00;
							state <= continuous_convert ? ST_CONVERT : ST_IDLE;
						end
						else
							cycle_count <= cycle_count + 5'h01;
					end
					else
						sar_start <= 1'b0;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Analog routing; selected input held for the whole conversion
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sar_power_on <= 1'b0;
			analog_mux_select <= MUX_NONE;
			port_a_pin0_analog <= 1'b0;
			port_a_pin1_analog <= 1'b0;
			port_a_pin4_analog <= 1'b0;
			port_a_pin5_analog <= 1'b0;
		end
		else
		begin
			sar_power_on <= ~power_off & ~stop_sync;
			analog_mux_select <= acc_mux_decode(channel_select);
			port_a_pin0_analog <= (acc_mux_decode(channel_select) == MUX_PIN0);
			port_a_pin1_analog <= (acc_mux_decode(channel_select) == MUX_PIN1);
			port_a_pin4_analog <= (acc_mux_decode(channel_select) == MUX_PIN4);
			port_a_pin5_analog <= (acc_mux_decode(channel_select) == MUX_PIN5);
		end
	end
endmodule

// *** src/acc_consts.vh ***
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
// Register byte addresses on the AHB-Lite slave
`define ACC_ADDR_STATUS_CONTROL 4'h0
`define ACC_ADDR_RESULT_DATA 4'h4
`define ACC_ADDR_CLOCK_DIVIDER 4'h8
`define ACC_ADDR_BITS 4
// Status/control field positions
`define ACC_BIT_DONE 7
`define ACC_BIT_IRQ_EN 6
`define ACC_BIT_CONT 5
`define ACC_CH_HI 4
`define ACC_CH_LO 0
// Clock divider field positions
`define ACC_DIV_HI 7
`define ACC_DIV_LO 5
// Reset values
`define ACC_CH_RESET 5'h1F
`define ACC_DIV_RESET 3'h0
// Channel codes
`define ACC_CH_POWER_OFF 5'h1F
`define ACC_CH_REF_HIGH 5'h1E
`define ACC_CH_REF_LOW 5'h1D
`define ACC_CH_LAST_PIN 5'h03
// Conversion length in ADC clock cycles
`define ACC_CONV_CYCLES 5'h10
// Prescaler codes
`define ACC_DIV_BY1 3'h0
`define ACC_DIV_BY2 3'h1
`define ACC_DIV_BY4 3'h2
`define ACC_DIV_BY8 3'h3
`define ACC_DIV_MAX 4'hF
`define ACC_DIV_M2 4'h1
`define ACC_DIV_M4 4'h3
`define ACC_DIV_M8 4'h7
// AHB encodings
`define ACC_HTRANS_NONSEQ_BIT 1
`define ACC_ZERO32 32'h00000000
`endif

// *** src/acc_prescaler.v ***
`timescale 1ns/1ps
// Divides the bus clock into a one-cycle ADC clock tick
module acc_prescaler
(
	input wire clk,
	input wire arst_n,
	input wire [2:0] prescale_select,
	input wire restart,
	output reg adc_tick
);
`include "acc_consts.vh"
	// Free counter, restarted on status/control writes
	reg [3:0] count;
	// Terminal count for the selected divide ratio
	reg [3:0] limit;

	// Top bit set means divide by sixteen
	always @*
	begin
		case (prescale_select)
			`ACC_DIV_BY1: limit = 4'h0;
			`ACC_DIV_BY2: limit = `ACC_DIV_M2;
			`ACC_DIV_BY4: limit = `ACC_DIV_M4;
			`ACC_DIV_BY8: limit = `ACC_DIV_M8;
			default: limit = `ACC_DIV_MAX;
		endcase
	end

	// Tick once per divided period
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count <= 4'h0;
			adc_tick <= 1'b0;
		end
		else if (restart)
		begin
			// First divided edge follows the write by one full period
			count <= 4'h0;
			adc_tick <= 1'b0;
		end
		else if (count >= limit)
		begin
			count <= 4'h0;
			adc_tick <= 1'b1;
		end
		else
		begin
			count <= count + 4'h1;
			adc_tick <= 1'b0;
		end
	end
endmodule

// *** test/acc_adc_control_test.sv ***
`timescale 1ns/1ps
`include "acc_consts.vh"
// Register-level bench for the conversion control
module acc_adc_control_test;
	reg clk = 1'b0;
	reg arst_n = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg stop_mode = 1'b0;
	wire hready;
	wire [31:0] hrdata;
	wire [7:0] sar_result;
	wire sar_ready;
	wire pwr;
	wire [2:0] mux;
	wire irq;
	integer num_errors = 0;
	integer n_compared = 0;
	integer i;
	integer n;
	reg [31:0] q = 32'h0;
	always #5 clk = ~clk;
	acc_adc_control dut
	(
		.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(), .stop_mode(stop_mode), .sar_result(sar_result),
		.sar_ready(sar_ready), .sar_start(), .sar_power_on(pwr), .analog_mux_select(mux),
		.port_a_pin0_analog(), .port_a_pin1_analog(), .port_a_pin4_analog(),
		.port_a_pin5_analog(), .conversion_irq(irq)
	);
	acc_analog_model ana (.clk(clk), .sar_power_on(pwr), .analog_mux_select(mux),
		.sar_result(sar_result), .sar_ready(sar_ready));
	// Counts and verdict, then stop
	task print_verdict;
	begin
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	// A wait ran out
	task hang;
	begin
		num_errors = num_errors + 1;
		print_verdict;
	end
	endtask
	task chk(input string name, input [31:0] seen, input [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("BAD %0s expected %h seen %h", name, exp, seen);
		end
	end
	endtask
	// Whole cycles; values read here are those sampled at the edge
	task tick(input integer c);
		repeat (c) @(posedge clk);
	endtask
	// Next edge with ready high, bounded
	task edge_rdy;
		integer k;
	begin
		k = 0;
		do
		begin
			tick(1);
			k = k + 1;
		end
		while (hready !== 1'b1 && k < 20);
		if (k >= 20)
			hang;
	end
	endtask
	// One single word transfer
	task xfer(input w, input [31:0] a, input [31:0] d);
	begin
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		edge_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy;
		// Read data taken at the edge that ends the data phase
		q = hrdata;
	end
	endtask
	task rd(input string name, input [31:0] a, input [31:0] exp);
	begin
		xfer(1'b0, a, 32'h0);
		chk(name, q, exp);
	end
	endtask
	// Poll status until the done flag shows
	task wait_flag;
	begin
		n = 0;
		q = 32'h0;
		while (q[`ACC_BIT_DONE] !== 1'b1 && n < 200)
		begin
			xfer(1'b0, `ACC_ADDR_STATUS_CONTROL, 32'h0);
			n = n + 1;
		end
		if (n >= 200)
			hang;
	end
	endtask
	task wait_irq;
	begin
		n = 0;
		while (irq !== 1'b1 && n < 400)
		begin
			tick(1);
			n = n + 1;
		end
		if (n >= 400)
			hang;
	end
	endtask
	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		tick(1);
		chk("power", pwr, 0);
		rd("ctl", 0, 32'h1F);
		rd("div", 8, 0);
		rd("res", 4, 0);
		rd("unmapped", 32'hC, 0);
		// First result after power-off is only for settling
		xfer(1'b1, 0, 32'h01);
		wait_flag;
		xfer(1'b0, 4, 0);
		for (i = 0; i < 5; i = i + 1)
		begin
			xfer(1'b1, 8, (i == 4) ? 32'hE0 : i * 32);
			rd("div", 8, (i == 4) ? 32'hE0 : i * 32);
			xfer(1'b1, 0, 32'h41);
			wait_irq;
			chk("time", n >= (16 << i) && n <= (17 << i) + 5, 1);
			rd("ctl", 0, 32'h41);
			chk("irq", irq, 1);
			rd("res", 4, 32'h22);
			tick(1);
			chk("irq", irq, 0);
		end
		xfer(1'b1, 8, 0);
		xfer(1'b1, 0, 32'h43);
		wait_irq;
		xfer(1'b1, 0, 32'h03);
		tick(1);
		chk("irq", irq, 0);
		wait_flag;
		chk("irq", irq, 0);
		tick(40);
		rd("ctl", 0, 32'h83);
		rd("res", 4, 32'h55);
		rd("ctl", 0, 32'h03);
		tick(60);
		rd("ctl", 0, 32'h03);
		xfer(1'b1, 0, 32'h3E);
		wait_flag;
		rd("res", 4, 32'hFF);
		wait_flag;
		rd("res", 4, 32'hFF);
		xfer(1'b1, 0, 32'h3D);
		tick(20);
		xfer(1'b0, 4, 0);
		wait_flag;
		rd("res", 4, 32'h00);
		stop_mode <= 1'b1;
		tick(6);
		chk("power", pwr, 0);
		xfer(1'b0, 4, 0);
		stop_mode <= 1'b0;
		wait_flag;
		xfer(1'b0, 4, 0);
		wait_flag;
		rd("res", 4, 32'h00);
		xfer(1'b1, 0, 32'h1F);
		tick(3);
		chk("power", pwr, 0);
		tick(40);
		rd("ctl", 0, 32'h1F);
		print_verdict;
	end
endmodule

// *** test/acc_adc_properties.sv ***
`timescale 1ns/1ps
// Port relations of the conversion control
module acc_adc_checker
(
	input wire clk,
	input wire arst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire sar_start,
	input wire sar_power_on,
	input wire [2:0] analog_mux_select,
	input wire port_a_pin0_analog,
	input wire port_a_pin1_analog,
	input wire port_a_pin4_analog,
	input wire port_a_pin5_analog,
	input wire conversion_irq
);
	// Access taken at this edge
	wire acc = hsel && hready && htrans[1];
	// Pin flags, pin0 in bit 0
	wire [3:0] pins = {port_a_pin5_analog, port_a_pin4_analog, port_a_pin1_analog,
		port_a_pin0_analog};
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	irq_level_a: assert property (conversion_irq && !acc && !$past(acc) |=> conversion_irq)
		else $error("irq dropped without access");
	pin_route_a: assert property (pins == (analog_mux_select < 3'h4 ? 4'h1 << analog_mux_select : 4'h0))
		else $error("pin flags disagree with mux");
	power_start_a: assert property (!sar_power_on && !$past(sar_power_on) |-> !sar_start)
		else $error("start while powered off");
	start_pulse_a: assert property (sar_start |=> !sar_start)
		else $error("start longer than one cycle");
	idle_rdata_a: assert property (!$past(acc && !hwrite) |-> hrdata == 32'h0)
		else $error("read data outside data phase");
	upper_zero_a: assert property ($past(acc && !hwrite) |-> hrdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	unmapped_read_a: assert property ($past(acc && !hwrite && haddr == 32'hC) |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule

bind acc_adc_control acc_adc_checker chk (.clk(clk), .arst_n(arst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .sar_start(sar_start), .sar_power_on(sar_power_on),
	.analog_mux_select(analog_mux_select), .port_a_pin0_analog(port_a_pin0_analog),
	.port_a_pin1_analog(port_a_pin1_analog), .port_a_pin4_analog(port_a_pin4_analog),
	.port_a_pin5_analog(port_a_pin5_analog), .conversion_irq(conversion_irq));

// *** test/acc_analog_model.sv ***
`timescale 1ns/1ps
// Input levels seen by the converter, held steady per pin or reference selection
module acc_analog_model
(
	input wire clk,
	input wire sar_power_on,
	input wire [2:0] analog_mux_select,
	output reg [7:0] sar_result = 8'h00,
	output reg sar_ready = 1'b0
);
	// Moving pattern, so no selection never looks valid
	reg [7:0] noise = 8'h00;
	// Level per selected input
	always @(posedge clk)
	begin
		noise <= noise + 8'h5B;
		sar_ready <= sar_power_on;
		case (analog_mux_select)
			3'h0: sar_result <= 8'h11;
			3'h1: sar_result <= 8'h22;
			3'h2: sar_result <= 8'h44;
			3'h3: sar_result <= 8'h55;
			3'h4: sar_result <= 8'hFF;
			3'h5: sar_result <= 8'h00;
			default: sar_result <= noise;
		endcase
	end
endmodule
